// ===== bench/test_vfc_config_top.sv
// self-checking bench for the serial configuration block
`timescale 1ns/1ps
`default_nettype none
module test_vfc_config_top;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [1:0] pins = 2'b10;
  logic       hsync = 1'b0;
  logic       intSync = 1'b0;
  logic       scl, sdaPull, sdaOut, sdaOe, clampActive, ack;
  logic       pd, burst, extMode, polNeg, bypass, clamp1, clamp2, clamp3;
  logic [7:0] cutoffCode, ctl, expCsr, expFreq, rd;
  wire logic  sdaWire;
  int         failures = 0;
  int         n_compared = 0;
  assign sdaWire = !(sdaPull || sdaOe);
  assign ctl = {pd, bypass, polNeg, extMode, burst, clamp3, clamp2, clamp1};
  always #2 clk = ~clk;
  vfc_config_top u_dut (.clk(clk), .reset(reset), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_select_bit1(pins[1]), .addr_select_bit0(pins[0]),
    .external_hsync_input(hsync), .internalSyncDetect(intSync), .analogPowerDown(pd),
    .colorBurstFilterEnable(burst), .externalSyncMode(extMode), .syncPolarityNegative(polNeg),
    .filterBypass(bypass), .clampLevelHigh1(clamp1), .clampLevelHigh2(clamp2),
    .clampLevelHigh3(clamp3), .clampActive(clampActive), .cutoffCode(cutoffCode));
  vfc_bus_master u_m (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaPull(sdaPull));
  task automatic report_and_stop();
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] s, input logic [7:0] c);
    if (c <= 8'h01) s[7] = ~c[0];
    else if (c <= 8'h07) s[c[2:1] - 2'h1] = c[0];
    else if (c <= 8'h0F) s[{1'b0, c[2:1]} + 3'h3] = c[0] ^ (c[2:1] == 2'h0 || c[2:1] == 2'h3);
    else if (c == 8'h10) s = 8'h00;
    return s;
  endfunction
  task automatic byteAck(input logic [7:0] b);
    u_m.sendByte(b, ack);
    chk("ack", 8'h01, {7'h0, ack});
  endtask
  task automatic open(input logic rw);
    u_m.startCond();
    byteAck({5'h12, pins, rw});
  endtask
  task automatic cmd(input logic [7:0] c);
    open(1'b0);
    byteAck(c);
    u_m.stopCond();
    expCsr = nxt(expCsr, c);
    chk("control", expCsr, ctl);
    chk("cutoff", expFreq, cutoffCode);
  endtask
  task automatic freq(input logic [7:0] v);
    open(1'b0);
    byteAck(8'h12);
    byteAck(v);
    u_m.stopCond();
    expFreq = v;
    chk("cutoff", expFreq, cutoffCode);
  endtask
  task automatic t_commands();
    chk("control", 8'h00, ctl);
    chk("cutoff", 8'h00, cutoffCode);
    freq(8'h00);
    freq(8'hFF);
    freq(8'h5A);
    for (int c = 2; c <= 17; c++) cmd(c[7:0]);
  endtask
  task automatic t_chain();
    open(1'b0);
    byteAck(8'h12);
    byteAck(8'hA5);
    byteAck(8'h0E);
    u_m.startCond();
    byteAck({5'h12, pins, 1'b0});
    byteAck(8'h03);
    u_m.stopCond();
    expFreq = 8'hA5;
    expCsr = nxt(nxt(expCsr, 8'h0E), 8'h03);
    chk("control", expCsr, ctl);
    chk("cutoff", expFreq, cutoffCode);
    open(1'b1);
    u_m.readByte(1'b1, rd);
    chk("status", expCsr, rd);
    u_m.readByte(1'b0, rd);
    u_m.stopCond();
    chk("status", expCsr, rd);
  endtask
  task automatic t_abort();
    logic s;
    open(1'b0);
    byteAck(8'h12);
    for (int i = 0; i < 4; i++) u_m.clockBit(1'b0, s);
    u_m.stopCond();
    chk("cutoff", expFreq, cutoffCode);
    open(1'b0);
    for (int i = 0; i < 5; i++) u_m.clockBit(1'b1, s);
    u_m.stopCond();
    chk("control", expCsr, ctl);
  endtask
  task automatic t_address();
    pins = 2'b01;
    u_m.wt(6);
    u_m.startCond();
    u_m.sendByte({5'h12, 2'b10, 1'b0}, ack);
    chk("nack", 8'h00, {7'h0, ack});
    u_m.sendByte(8'h0F, ack);
    u_m.stopCond();
    chk("control", expCsr, ctl);
    cmd(8'h0F);
  endtask
  task automatic t_sync_power();
    cmd(8'h0B);
    for (int i = 0; i < 4; i++) begin
      cmd(8'h0C + {7'h0, i[1]});
      hsync = i[0];
      u_m.wt(8);
      chk("clamp", {7'h0, i[0] ^ i[1]}, {7'h0, clampActive});
    end
    cmd(8'h0A);
    intSync = 1'b1;
    u_m.wt(8);
    chk("clamp", 8'h01, {7'h0, clampActive});
    cmd(8'h00);
    chk("clamp", 8'h00, {7'h0, clampActive});
    freq(8'h3C);
    cmd(8'h01);
  endtask
  initial begin
    expCsr = 8'h00;
    expFreq = 8'h00;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    u_m.wt(6);
    t_commands();
    t_chain();
    t_abort();
    t_address();
    t_sync_power();
    report_and_stop();
  end
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== bench/vfc_bus_master.sv
// bus master model driving the serial configuration link
`timescale 1ns/1ps
`default_nettype none
module vfc_bus_master (
  input  wire logic clk,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaPull
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic clockBit(input logic pull, output logic seen);
    wt(2);
    sdaPull = pull;
    wt(4);
    scl = 1'b1;
    wt(6);
    seen = sdaWire;
    scl = 1'b0;
  endtask
  task automatic startCond();
    wt(2);
    sdaPull = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(6);
    sdaPull = 1'b1;
    wt(6);
    scl = 1'b0;
  endtask
  task automatic stopCond();
    wt(2);
    sdaPull = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(6);
    sdaPull = 1'b0;
    wt(6);
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clockBit(~b[i], s);
    clockBit(1'b0, s);
    ack = ~s;
  endtask
  task automatic readByte(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++) begin
      clockBit(1'b0, s);
      d = {d[6:0], s};
    end
    clockBit(ackIt, s);
  endtask
endmodule
`default_nettype wire

// ===== bench/vfc_config_monitor.sv
// port assertions for the serial configuration block
`timescale 1ns/1ps
`default_nettype none
module vfc_config_monitor (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       sclIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       external_hsync_input,
  input wire logic       internalSyncDetect,
  input wire logic       analogPowerDown,
  input wire logic       colorBurstFilterEnable,
  input wire logic       externalSyncMode,
  input wire logic       syncPolarityNegative,
  input wire logic       filterBypass,
  input wire logic       clampActive,
  input wire logic [7:0] cutoffCode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [12:0] cfg;
  assign cfg = {analogPowerDown, colorBurstFilterEnable, externalSyncMode,
                syncPolarityNegative, filterBypass, cutoffCode};
  sequence s_ext_settled;
    (externalSyncMode && !analogPowerDown && $stable(syncPolarityNegative)) [*4];
  endsequence
  sequence s_int_settled;
    (!externalSyncMode && !analogPowerDown) [*4];
  endsequence
  a_sda_open_drain: assert property (sdaOut == 1'b0)
    else $error("data drive value not low");
  a_reset_defaults: assert property ($fell(reset) |-> cfg == 13'h0000 && !sdaOe && !clampActive)
    else $error("outputs not at defaults after reset");
  a_cfg_after_ack: assert property ($changed(cfg) |-> $past(sdaOe) || $past(sdaOe, 2) || $past(sdaOe, 3))
    else $error("configuration changed outside acknowledge end");
  a_clamp_powerdown: assert property (analogPowerDown && $past(analogPowerDown) |-> !clampActive)
    else $error("clamp active while powered down");
  a_ext_sync_clamp: assert property (s_ext_settled |-> clampActive == ($past(external_hsync_input, 3) ^ syncPolarityNegative))
    else $error("clamp does not follow external sync");
  a_int_sync_clamp: assert property (s_int_settled |-> clampActive == $past(internalSyncDetect, 3))
    else $error("clamp does not follow internal sync");
  a_ack_after_fall: assert property ($rose(sdaOe) |-> !sclIn && !$past(sclIn, 2))
    else $error("data pulled low outside clock low phase");
  a_quiet_clock_high: assert property (sclIn && $past(sclIn, 3) |-> $stable(sdaOe))
    else $error("data drive changed while clock high");
  a_drive_released: assert property ($rose(sdaOe) |-> ##[1:120] !sdaOe)
    else $error("data line held low too long");
  a_wake_keeps_freq: assert property ($fell(analogPowerDown) |-> $stable(cutoffCode))
    else $error("frequency changed on leaving power-down");
endmodule
bind vfc_config_top vfc_config_monitor u_mon (
  .clk(clk), .reset(reset), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .external_hsync_input(external_hsync_input), .internalSyncDetect(internalSyncDetect),
  .analogPowerDown(analogPowerDown), .colorBurstFilterEnable(colorBurstFilterEnable),
  .externalSyncMode(externalSyncMode), .syncPolarityNegative(syncPolarityNegative),
  .filterBypass(filterBypass), .clampActive(clampActive), .cutoffCode(cutoffCode));
`default_nettype wire

// ===== common/vfc_consts.svh
// constants for the video filter serial configuration block
// Overview of operation
// R1 - composite mode enables color-burst filter
// R2 - external sync mode clamps from external pin
// R3 - external sync polarity chosen by command
// R4 - command 12h then data loads frequency
// R5 - frequency code picks one of 256 steps
// R6 - 0Eh enables bypass, 0Fh disables it
// R7 - power-down and wake-up only by command
// R8 - serial interface keeps running while powered down
// R9 - wake-up keeps settings held before power-down
// R10 - software reset restores control, keeps frequency
// R11 - power-on reset clears registers and interface
// R12 - interface works at bus clocks to 400kHz
// R13 - valid command updates control, gates frequency
// R14 - slave only, never drives the clock
// R15 - master frames address and bytes, START/STOP
// R16 - one data bit per clock rising edge
// R17 - nine clocks per byte including acknowledge
// R18 - transmitter keeps data stable while clock high
// R19 - data change during clock high is control
// R20 - data line open-drain, pulled low or released
// R21 - idle bus lines rest high
// R22 - address 10010 plus two select pins, MSB first
// R23 - 00h powers down, 01h wakes up
// R24 - acknowledge address and data on ninth clock
// R25 - aborted write leaves the register unchanged
// R26 - unknown commands acknowledged, change nothing
`ifndef VFC_CONSTS_SVH
`define VFC_CONSTS_SVH

`define VFC_ADDR_FIXED      5'h12
`define VFC_BYTE_BITS       4'h8
`define VFC_SYNC_WIDTH      6

`define VFC_PIN_SEL1        0
`define VFC_PIN_SCL         1
`define VFC_PIN_SDA         2
`define VFC_PIN_HSYNC       3
`define VFC_PIN_INT_SYNC    4
`define VFC_PIN_SEL0        5

`define VFC_CMD_POWER_DOWN  8'h00
`define VFC_CMD_WAKE_UP     8'h01
`define VFC_CMD_CLAMP1_LOW  8'h02
`define VFC_CMD_CLAMP1_HIGH 8'h03
`define VFC_CMD_CLAMP2_LOW  8'h04
`define VFC_CMD_CLAMP2_HIGH 8'h05
`define VFC_CMD_CLAMP3_LOW  8'h06
`define VFC_CMD_CLAMP3_HIGH 8'h07
`define VFC_CMD_COMPOSITE   8'h08
`define VFC_CMD_COMPONENT   8'h09
`define VFC_CMD_INT_SYNC    8'h0A
`define VFC_CMD_EXT_SYNC    8'h0B
`define VFC_CMD_POL_POS     8'h0C
`define VFC_CMD_POL_NEG     8'h0D
`define VFC_CMD_BYPASS_ON   8'h0E
`define VFC_CMD_BYPASS_OFF  8'h0F
`define VFC_CMD_SOFT_RESET  8'h10
`define VFC_CMD_FREQUENCY   8'h12

`define VFC_FREQ_RESET      8'h00

`endif

// ===== common/vfc_pkg.sv
// types for the video filter serial configuration block
package vfc_pkg;

  typedef enum logic [3:0] {
    VFC_IDLE,
    VFC_ADDR,
    VFC_ADDR_ACK,
    VFC_CMD,
    VFC_CMD_ACK,
    VFC_DATA,
    VFC_DATA_ACK,
    VFC_TX,
    VFC_TX_ACK
  } vfc_state_e;

  typedef struct packed {
    logic powerDown;
    logic bypass;
    logic polarityNegative;
    logic externalSync;
    logic composite;
    logic clampHigh3;
    logic clampHigh2;
    logic clampHigh1;
  } vfc_csr_s;

  typedef struct packed {
    vfc_state_e state;
    logic [3:0] bitCount;
    logic [7:0] shiftReg;
    logic [7:0] commandHeld;
    logic       readMode;
    logic       masterAck;
    logic       startThisHigh;
    logic       sclPrev;
    logic       sdaPrev;
    logic       sdaPull;
    logic       clampActive;
    vfc_csr_s   csr;
    logic [7:0] frequency;
  } vfc_state_s;

endpackage

// ===== rtl/vfc_config_top.sv
// serial configuration slave and command interpreter of the video filter
`timescale 1ns/1ps
`default_nettype none
`include "vfc_consts.svh"
module vfc_config_top (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       addr_select_bit1,
  input  wire logic       addr_select_bit0,
  input  wire logic       external_hsync_input,
  input  wire logic       internalSyncDetect,
  output logic            analogPowerDown,
  output logic            colorBurstFilterEnable,
  output logic            externalSyncMode,
  output logic            syncPolarityNegative,
  output logic            filterBypass,
  output logic            clampLevelHigh1,
  output logic            clampLevelHigh2,
  output logic            clampLevelHigh3,
  output logic            clampActive,
  output logic [7:0]      cutoffCode
);

  // reset value of the control/status fields
  localparam vfc_pkg::vfc_csr_s CSR_DEFAULT = '{
    powerDown:        1'b0,
    bypass:           1'b0,
    polarityNegative: 1'b0,
    externalSync:     1'b0,
    composite:        1'b0,
    clampHigh3:       1'b0,
    clampHigh2:       1'b0,
    clampHigh1:       1'b0
  };

  // reset value of the whole state
  localparam vfc_pkg::vfc_state_s STATE_RESET = '{
    state:         vfc_pkg::VFC_IDLE,
    bitCount:      4'h0,
    shiftReg:      8'h00,
    commandHeld:   8'h00,
    readMode:      1'b0,
    masterAck:     1'b0,
    startThisHigh: 1'b0,
    sclPrev:       1'b1,
    sdaPrev:       1'b1,
    sdaPull:       1'b0,
    clampActive:   1'b0,
    csr:           CSR_DEFAULT,
    frequency:     `VFC_FREQ_RESET
  };

  vfc_pkg::vfc_state_s st;
  vfc_pkg::vfc_state_s next_st;

  logic [`VFC_SYNC_WIDTH-1:0] pinsRaw;
  logic [`VFC_SYNC_WIDTH-1:0] pinsSync;
  logic                       scl;
  logic                       sdaEarly;
  logic                       sda;
  logic                       hsync;
  logic                       intSync;
  logic                       selBit1;
  logic                       selBit0;
  logic                       sclRise;
  logic                       sclFall;
  logic                       startSeen;
  logic                       stopSeen;
  logic [6:0]                 ownAddress;

  // every pin crosses two flip-flops before use
  assign pinsRaw = {addr_select_bit0, internalSyncDetect, external_hsync_input, sdaIn, sclIn,
                    addr_select_bit1};

  vfc_sync2 #(
    .WIDTH (`VFC_SYNC_WIDTH)
  ) u_sync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (pinsRaw),
    .syncOut (pinsSync)
  );

  assign selBit1  = pinsSync[`VFC_PIN_SEL1];
  assign scl      = pinsSync[`VFC_PIN_SCL];
  assign sdaEarly = pinsSync[`VFC_PIN_SDA];
  assign hsync    = pinsSync[`VFC_PIN_HSYNC];
  assign intSync  = pinsSync[`VFC_PIN_INT_SYNC];
  assign selBit0  = pinsSync[`VFC_PIN_SEL0];

  // data seen two clocks behind the clock line, so a master that moves
  // data right at the clock fall never looks like a start or a stop
  vfc_sync2 u_sdaLag (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (sdaEarly),
    .syncOut (sda)
  ); // R19

  // fixed upper bits plus select pins
  assign ownAddress = {`VFC_ADDR_FIXED, selBit1, selBit0}; // R22

  // clock edges found by oversampling; 250MHz leaves hundreds of samples
  // per half period of a 400kHz bus clock
  assign sclRise = scl & ~st.sclPrev; // R12 R16
  assign sclFall = ~scl & st.sclPrev;

  // data change while clock high is a bus condition
  assign startSeen = scl & st.sclPrev & st.sdaPrev & ~sda; // R19
  assign stopSeen  = scl & st.sclPrev & ~st.sdaPrev & sda; // R19

  // command interpreter for the control/status fields
  function automatic vfc_pkg::vfc_csr_s applyCommand(
    input vfc_pkg::vfc_csr_s c,
    input logic [7:0]        cmd
  );
    vfc_pkg::vfc_csr_s r;
    r = c;
    case (cmd)
      `VFC_CMD_POWER_DOWN:  r.powerDown        = 1'b1; // R7 R23
      `VFC_CMD_WAKE_UP:     r.powerDown        = 1'b0; // R7 R9 R23
      `VFC_CMD_CLAMP1_LOW:  r.clampHigh1       = 1'b0;
      `VFC_CMD_CLAMP1_HIGH: r.clampHigh1       = 1'b1;
      `VFC_CMD_CLAMP2_LOW:  r.clampHigh2       = 1'b0;
      `VFC_CMD_CLAMP2_HIGH: r.clampHigh2       = 1'b1;
      `VFC_CMD_CLAMP3_LOW:  r.clampHigh3       = 1'b0;
      `VFC_CMD_CLAMP3_HIGH: r.clampHigh3       = 1'b1;
      `VFC_CMD_COMPOSITE:   r.composite        = 1'b1; // R1
      `VFC_CMD_COMPONENT:   r.composite        = 1'b0; // R1
      `VFC_CMD_INT_SYNC:    r.externalSync     = 1'b0; // R2
      `VFC_CMD_EXT_SYNC:    r.externalSync     = 1'b1; // R2
      `VFC_CMD_POL_POS:     r.polarityNegative = 1'b0; // R3
      `VFC_CMD_POL_NEG:     r.polarityNegative = 1'b1; // R3
      `VFC_CMD_BYPASS_ON:   r.bypass           = 1'b1; // R6
      `VFC_CMD_BYPASS_OFF:  r.bypass           = 1'b0; // R6
      `VFC_CMD_SOFT_RESET:  r = CSR_DEFAULT; // R10
      default:              r = c; // R26
    endcase
    return r;
  endfunction

  always_comb begin
    next_st = st;
    next_st.sclPrev = scl;
    next_st.sdaPrev = sda;

    // a start is remembered until the clock goes low
    if (sclFall) begin
      next_st.startThisHigh = 1'b0;
    end

    // bus engine keeps running in power-down
    case (st.state) // R8
      vfc_pkg::VFC_IDLE: begin
        // ignore everything until a start
        next_st.sdaPull = 1'b0; // R21
      end

      vfc_pkg::VFC_ADDR, vfc_pkg::VFC_CMD, vfc_pkg::VFC_DATA: begin
        if (sclRise) begin
          // shift in msb first, one bit per rising edge
          next_st.shiftReg = {st.shiftReg[6:0], sda}; // R16
          next_st.bitCount = st.bitCount + 4'h1; // R17
        end else if (sclFall && st.bitCount == `VFC_BYTE_BITS) begin
          if (st.state == vfc_pkg::VFC_ADDR) begin
            if (st.shiftReg[7:1] == ownAddress) begin
              next_st.readMode = st.shiftReg[0];
              next_st.sdaPull  = 1'b1; // R24
              next_st.state    = vfc_pkg::VFC_ADDR_ACK;
            end else begin
              // foreign address: bus ignored until next start
              next_st.state = vfc_pkg::VFC_IDLE;
            end
          end else if (st.state == vfc_pkg::VFC_CMD) begin
            // every command byte is acknowledged
            next_st.commandHeld = st.shiftReg;
            next_st.sdaPull     = 1'b1; // R24 R26
            next_st.state       = vfc_pkg::VFC_CMD_ACK;
          end else begin
            next_st.sdaPull = 1'b1; // R24
            next_st.state   = vfc_pkg::VFC_DATA_ACK;
          end
        end
      end

      vfc_pkg::VFC_ADDR_ACK: begin
        // ninth clock ends with its falling edge
        if (sclFall) begin
          next_st.bitCount = 4'h0;
          if (st.readMode) begin
            // first status bit goes out at once
            next_st.shiftReg = st.csr;
            next_st.sdaPull  = ~st.csr.powerDown; // R20
            next_st.state    = vfc_pkg::VFC_TX;
          end else begin
            next_st.sdaPull = 1'b0;
            next_st.state   = vfc_pkg::VFC_CMD;
          end
        end
      end

      vfc_pkg::VFC_CMD_ACK: begin
        // command takes effect only once its byte is complete
        if (sclFall) begin
          next_st.sdaPull  = 1'b0;
          next_st.bitCount = 4'h0;
          next_st.csr      = applyCommand(st.csr, st.commandHeld); // R13
          if (st.commandHeld == `VFC_CMD_FREQUENCY) begin
            // next byte is admitted to the frequency register
            next_st.state = vfc_pkg::VFC_DATA; // R4 R13
          end else begin
            next_st.state = vfc_pkg::VFC_CMD;
          end
        end
      end

      vfc_pkg::VFC_DATA_ACK: begin
        if (sclFall) begin
          next_st.sdaPull   = 1'b0;
          next_st.bitCount  = 4'h0;
          next_st.frequency = st.shiftReg; // R4 R5
          next_st.state     = vfc_pkg::VFC_CMD;
        end
      end

      vfc_pkg::VFC_TX: begin
        // data changes only while the clock is low
        if (sclRise) begin
          next_st.bitCount = st.bitCount + 4'h1; // R16
        end else if (sclFall) begin
          if (st.bitCount == `VFC_BYTE_BITS) begin
            // release for the master acknowledge
            next_st.sdaPull = 1'b0; // R17 R20
            next_st.state   = vfc_pkg::VFC_TX_ACK;
          end else begin
            next_st.shiftReg = {st.shiftReg[6:0], 1'b0};
            next_st.sdaPull  = ~st.shiftReg[6]; // R20
          end
        end
      end

      vfc_pkg::VFC_TX_ACK: begin
        if (sclRise) begin
          next_st.masterAck = ~sda;
        end else if (sclFall) begin
          next_st.bitCount = 4'h0;
          if (st.masterAck) begin
            next_st.shiftReg = st.csr;
            next_st.sdaPull  = ~st.csr.powerDown; // R20
            next_st.state    = vfc_pkg::VFC_TX;
          end else begin
            next_st.state = vfc_pkg::VFC_IDLE;
          end
        end
      end

      default: begin
        next_st.state   = vfc_pkg::VFC_IDLE;
        next_st.sdaPull = 1'b0;
      end
    endcase

    // bus conditions override the byte engine
    if (startSeen) begin
      next_st.state         = vfc_pkg::VFC_ADDR; // R15
      next_st.bitCount      = 4'h0;
      next_st.sdaPull       = 1'b0;
      next_st.startThisHigh = 1'b1;
    end else if (stopSeen && !st.startThisHigh) begin
      // partial byte dropped, nothing is written
      next_st.state    = vfc_pkg::VFC_IDLE; // R25
      next_st.bitCount = 4'h0;
      next_st.sdaPull  = 1'b0; // R21
    end

    // clamp timing from the selected sync source
    if (next_st.csr.powerDown) begin
      next_st.clampActive = 1'b0; // R7
    end else if (next_st.csr.externalSync) begin
      next_st.clampActive = hsync ^ next_st.csr.polarityNegative; // R2 R3
    end else begin
      next_st.clampActive = intSync;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= STATE_RESET; // R11
    end else begin
      st <= next_st;
    end
  end

  // open-drain data: only ever pulls low, clock is never driven
  assign sdaOut = 1'b0; // R14 R20
  assign sdaOe  = st.sdaPull; // R20

  assign analogPowerDown        = st.csr.powerDown; // R7
  assign colorBurstFilterEnable = st.csr.composite; // R1
  assign externalSyncMode       = st.csr.externalSync; // R2
  assign syncPolarityNegative   = st.csr.polarityNegative; // R3
  assign filterBypass           = st.csr.bypass; // R6
  assign clampLevelHigh1        = st.csr.clampHigh1;
  assign clampLevelHigh2        = st.csr.clampHigh2;
  assign clampLevelHigh3        = st.csr.clampHigh3;
  assign clampActive            = st.clampActive;
  assign cutoffCode             = st.frequency; // R5

endmodule
`default_nettype wire

// ===== rtl/vfc_sync2.sv
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module vfc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] firstStage;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge clk) begin
        if (reset) begin
          firstStage[i] <= 1'b1;
          syncOut[i]    <= 1'b1;
        end else begin
          firstStage[i] <= asyncIn[i];
          syncOut[i]    <= firstStage[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire
